// file: hw/cmb_buf_mem.sv
// Message buffer storage: one 14-byte image per buffer, registered read
`timescale 1ns/1ns
`default_nettype none
module cmb_buf_mem #(
   parameter int DEPTH = 11,
   parameter int AW    = 4,
   parameter int W     = 112
) (
   input  wire logic          ref_clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem [DEPTH];

   // Single write port, no reset: contents are don't-care until loaded
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read keeps the frame image off combinational paths
   always_ff @(posedge ref_clk) begin
      rdata <= mem[raddr];
   end
endmodule : cmb_buf_mem
`default_nettype wire

// file: hw/cmb_msg_buf.sv
// Message buffer handling: tx queue, abort, auto reply, rx load
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Auto reply queues tx buffer on remote
// - Pending buffer ignores all writes
// - Send request clears three status flags
// - Request only marks ready; send when idle
// - Success clears request, sets done flag
// - Error keeps request, sets error flags
// - Lost arbitration keeps request, sets flag
// - Abort-all requests abort of everything
// - Abort unstarted or failed; done stays clear, but code sets it a cycle after success
// - Abort request uncancellable by firmware
// - Highest two-bit priority goes first
// - Equal priority: higher buffer number first
// - Assembly buffer fully overwrites target
// - Load sets full flag, locks buffer
// - Record filter hit and remote flag
// - Extended flag reflects identifier type
// - Mode 00 filters; 01 std, 10 ext in legacy mode
// - Mode 11 accepts all, partial frames
// - Filter hitting tx buffer discards frame
// - Programmable buffers reset to receive
module cmb_msg_buf #(
   parameter int NB = 11
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // Host side
   input  wire logic [1:0]           func_mode,
   input  wire logic                 abort_all_request,
   input  wire logic [5:0]           buffer_select_reg,
   input  wire logic                 wr_en,
   input  wire logic [3:0]           wr_buf,
   input  wire logic [111:0]         wr_image,
   input  wire logic [1:0]           wr_priority,
   input  wire logic                 wr_auto_reply,
   input  wire logic                 set_send_request,
   input  wire logic                 clr_send_request,
   input  wire logic [3:0]           ctl_buf,
   input  wire logic                 clr_full,
   input  wire logic                 clr_done_irq,
   input  wire logic                 clr_bus_err_irq,
   input  wire logic [NB-1:0]        send_done_irq_enable,
   input  wire logic [1:0]           receive_filter_mode,
   input  wire logic [3:0]           rd_buf,
   // Link side, same clock
   input  wire logic                 bus_idle,
   input  wire logic                 tx_done,
   input  wire logic                 tx_lost,
   input  wire logic                 tx_error,
   input  wire logic                 rx_valid,
   input  wire logic                 rx_error,
   input  wire logic                 rx_ext,
   input  wire logic                 rx_remote,
   input  wire logic                 rx_hit,
   input  wire logic [4:0]           rx_filter,
   input  wire logic [3:0]           rx_target,
   input  wire logic [111:0]         assembly_buffer,
   // Outputs
   output logic                      tx_start,
   output logic [3:0]                tx_buf,
   output logic [111:0]              rd_image,
   output logic [NB-1:0]             send_request,
   output logic [NB-1:0]             abort_done_flag,
   output logic [NB-1:0]             lost_arbitration_flag,
   output logic [NB-1:0]             send_error_flag,
   output logic [NB-1:0]             send_done_irq_flag,
   output logic                      bus_error_irq_flag,
   output logic [NB-1:0]             buffer_full_flag,
   output logic [NB-1:0]             rx_remote_flag,
   output logic [4:0]                filter_hit_code,
   output logic                      irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [NB-1:0]      dir;
   logic [1:0]         send_priority [NB];
   logic [NB-1:0]      auto_reply_enable;
   logic [NB-1:0]      abort_pend;
   cmb_pkg::cmb_txst_t txst;
   logic [3:0]         next_pick;
   logic               pick_ok;
   logic               enh;
   logic               mem_we;
   logic [3:0]         mem_addr;
   logic [111:0]       mem_wdata;
   logic               rx_accept;
   logic               reply_hit;
   logic [NB-1:0]      req_set;
   logic [NB-1:0]      req_clr;
   logic [4:0]         hit_code [NB];

   assign enh = (func_mode != cmb_pkg::CMB_MODE_LEGACY);

   // Buffer index helper used by several decoders
   function automatic logic [NB-1:0] onehot(input logic [3:0] idx);
      onehot = '0;
      if (int'(idx) < NB) begin
         onehot[idx] = 1'b1;
      end
   endfunction : onehot

   // Direction: dedicated tx fixed, programmable follow select reg outside legacy mode
   always_comb begin
      dir = cmb_pkg::DIR_RESET;
      for (int i = 0; i < 6; i++) begin
         dir[cmb_pkg::PROG_BASE + i] = enh & buffer_select_reg[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive acceptance per mode; target locked while full
   always_comb begin
      rx_accept = 1'b0;
      reply_hit = 1'b0;
      if ((rx_valid | rx_error) && int'(rx_target) < NB) begin
         if (dir[rx_target]) begin
            // A filter pointing at a tx buffer only triggers replies
            reply_hit = rx_valid & rx_hit & rx_remote & enh
                      & auto_reply_enable[rx_target]
                      & ~send_request[rx_target];
         end else if (!buffer_full_flag[rx_target]) begin
            case (receive_filter_mode)
               cmb_pkg::CMB_RFM_FILTER: rx_accept = rx_valid & rx_hit;
               cmb_pkg::CMB_RFM_STD:
                  rx_accept = rx_valid & rx_hit & (enh | ~rx_ext);
               cmb_pkg::CMB_RFM_EXT:
                  rx_accept = rx_valid & rx_hit & (enh | rx_ext);
               cmb_pkg::CMB_RFM_ALL: rx_accept = 1'b1;
               default: rx_accept = 1'b0;
            endcase
         end
      end
   end

   // Single write port: receive load wins, host writes refused if pending
   always_comb begin
      mem_we    = 1'b0;
      mem_addr  = wr_buf;
      mem_wdata = wr_image;
      if (rx_accept) begin
         mem_we    = 1'b1;
         mem_addr  = rx_target;
         mem_wdata = assembly_buffer;
         mem_wdata[cmb_pkg::EXT_BYTE_POS*8 + cmb_pkg::EXT_BIT_POS] = rx_ext;
      end else if (wr_en && int'(wr_buf) < NB && !send_request[wr_buf]) begin
         mem_we = 1'b1;
      end
   end

   cmb_buf_mem #(
      .DEPTH (NB),
      .AW    (4),
      .W     (cmb_pkg::BUF_W)
   ) u_mem (
      .ref_clk (ref_clk),
      .we      (mem_we),
      .waddr   (mem_addr),
      .wdata   (mem_wdata),
      .raddr   (rd_buf),
      .rdata   (rd_image)
   );

   // Per-buffer settings, frozen while pending
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_reply_enable <= '0;
         for (int i = 0; i < NB; i++) begin
            send_priority[i] <= 2'h0;
         end
      end else if (wr_en && int'(wr_buf) < NB && !send_request[wr_buf] && !rx_accept) begin
         send_priority[wr_buf]     <= wr_priority;
         auto_reply_enable[wr_buf] <= wr_auto_reply;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority pick: higher code wins, ties go to higher index
   always_comb begin
      next_pick = 4'h0;
      pick_ok   = 1'b0;
      for (int i = 0; i < NB; i++) begin
         if (send_request[i] && dir[i] && !abort_pend[i]) begin
            if (!pick_ok || send_priority[i] >= send_priority[next_pick]) begin
               next_pick = 4'(i);
               pick_ok   = 1'b1;
            end
         end
      end
   end

   // Transmit sequencer: start only on idle bus, one frame at a time
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txst     <= cmb_pkg::CMB_TX_IDLE;
         tx_start <= 1'b0;
         tx_buf   <= 4'h0;
      end else begin
         tx_start <= 1'b0;
         case (txst)
            cmb_pkg::CMB_TX_IDLE: begin
               if (bus_idle && pick_ok && !tx_start) begin
                  tx_start <= 1'b1;
                  tx_buf   <= next_pick;
                  txst     <= cmb_pkg::CMB_TX_BUSY;
               end
            end
            cmb_pkg::CMB_TX_BUSY: begin
               if (tx_done || tx_lost || tx_error) begin
                  txst <= cmb_pkg::CMB_TX_IDLE;
               end
            end
            default: txst <= cmb_pkg::CMB_TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Send request set and clear sources
   always_comb begin
      req_set = '0;
      req_clr = '0;
      if (set_send_request && !clr_send_request) begin
         req_set = onehot(ctl_buf) & dir;
      end
      if (reply_hit) begin
         req_set = req_set | onehot(rx_target);
      end
      if (txst == cmb_pkg::CMB_TX_BUSY) begin
         if (tx_done) begin
            req_clr = onehot(tx_buf);
         end else if ((tx_lost || tx_error) && abort_pend[tx_buf]) begin
            req_clr = onehot(tx_buf);
         end
      end
      for (int i = 0; i < NB; i++) begin
         if (abort_pend[i] && !(txst == cmb_pkg::CMB_TX_BUSY && tx_buf == 4'(i))) begin
            req_clr[i] = 1'b1;
         end
      end
   end

   // Send request register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         send_request <= '0;
      end else begin
         send_request <= (send_request & ~req_clr) | (req_set & ~send_request);
      end
   end

   // Abort requests: only hardware retires them
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         abort_pend <= '0;
      end else begin
         for (int i = 0; i < NB; i++) begin
            if ((abort_all_request || (clr_send_request && ctl_buf == 4'(i)))
                && send_request[i]) begin
               abort_pend[i] <= 1'b1;
            end else if (!send_request[i]) begin
               abort_pend[i] <= 1'b0;
            end
         end
      end
   end

   // Status flags: done and bus error sets win over their clears; a new send request clears the other three ahead of any set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         abort_done_flag       <= '0;
         lost_arbitration_flag <= '0;
         send_error_flag       <= '0;
         send_done_irq_flag    <= '0;
         bus_error_irq_flag    <= 1'b0;
      end else begin
         for (int i = 0; i < NB; i++) begin
            if (req_set[i] && !send_request[i]) begin
               abort_done_flag[i]       <= 1'b0;
               lost_arbitration_flag[i] <= 1'b0;
               send_error_flag[i]       <= 1'b0;
            end else begin
               if (abort_pend[i] && req_clr[i]) begin
                  abort_done_flag[i] <= ~(tx_done && tx_buf == 4'(i));
               end
               if (txst == cmb_pkg::CMB_TX_BUSY && tx_buf == 4'(i)) begin
                  if (tx_lost) lost_arbitration_flag[i] <= 1'b1;
                  if (tx_error) send_error_flag[i] <= 1'b1;
               end
            end
            if (txst == cmb_pkg::CMB_TX_BUSY && tx_done && tx_buf == 4'(i)) begin
               send_done_irq_flag[i] <= 1'b1;
            end else if (clr_done_irq && ctl_buf == 4'(i)) begin
               send_done_irq_flag[i] <= 1'b0;
            end
         end
         if (txst == cmb_pkg::CMB_TX_BUSY && tx_error) begin
            bus_error_irq_flag <= 1'b1;
         end else if (clr_bus_err_irq) begin
            bus_error_irq_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive status: full lockout, filter hit and remote marker
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         buffer_full_flag <= '0;
         rx_remote_flag   <= '0;
         for (int i = 0; i < NB; i++) begin
            hit_code[i] <= 5'h00;
         end
      end else begin
         for (int i = 0; i < NB; i++) begin
            if (rx_accept && rx_target == 4'(i)) begin
               buffer_full_flag[i] <= 1'b1;
               rx_remote_flag[i]   <= rx_remote;
               hit_code[i] <= enh ? rx_filter : {2'h0, rx_filter[2:0]};
            end else if (clr_full && ctl_buf == 4'(i)) begin
               buffer_full_flag[i] <= 1'b0;
            end
         end
      end
   end

   // Hit code of the buffer being read, plus interrupt summary
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         filter_hit_code <= 5'h00;
         irq             <= 1'b0;
      end else begin
         filter_hit_code <= (int'(rd_buf) < NB) ? hit_code[rd_buf] : 5'h00;
         irq <= |(send_done_irq_flag & send_done_irq_enable) | bus_error_irq_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_done_clears_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (txst == cmb_pkg::CMB_TX_BUSY && tx_done) |=> !send_request[tx_buf]
         && send_done_irq_flag[$past(tx_buf)]) else $error("done did not retire");
   a_err_keeps_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (txst == cmb_pkg::CMB_TX_BUSY && tx_error && !abort_pend[tx_buf]
       && !req_set[tx_buf])
      |=> send_request[$past(tx_buf)] && bus_error_irq_flag) else $error("error lost req");
   a_lost_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (txst == cmb_pkg::CMB_TX_BUSY && tx_lost && !abort_pend[tx_buf])
      |=> send_request[$past(tx_buf)] && lost_arbitration_flag[$past(tx_buf)])
      else $error("lost arb wrong");
   a_start_on_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tx_start |-> $past(bus_idle) && send_request[tx_buf]) else $error("bad start");
   a_full_locks: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rx_valid && int'(rx_target) < NB && buffer_full_flag[rx_target] && !clr_full)
      |=> buffer_full_flag[$past(rx_target)]
          && hit_code[$past(rx_target)] == $past(hit_code[rx_target]))
      else $error("full overwritten");
   a_load_sets_full: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_accept |=> buffer_full_flag[$past(rx_target)]) else $error("full not set");
   a_set_clears_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (req_set[ctl_buf] && !send_request[ctl_buf] && set_send_request)
      |=> !abort_done_flag[$past(ctl_buf)]) else $error("flags not cleared");
   a_reply_queues: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reply_hit |=> send_request[$past(rx_target)]) else $error("no auto reply");
   a_std_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!enh && receive_filter_mode == 2'h1 && rx_ext) |-> !rx_accept)
      else $error("ext in std mode");
   c_reply: cover property (@(posedge ref_clk) disable iff (!rst_n) reply_hit);
   c_abort: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(|abort_done_flag));
   c_retry: cover property (@(posedge ref_clk) disable iff (!rst_n) tx_lost ##[1:50] tx_start);
endmodule : cmb_msg_buf
`default_nettype wire

// file: include/cmb_pkg.sv
// Package for the message buffer handling block: constants and types
package cmb_pkg;
   // Buffer counts: three dedicated tx, two dedicated rx, six programmable
   localparam int NUM_BUF      = 11;
   localparam int BUF_IDX_W    = 4;
   localparam int PROG_BASE    = 5;
   // Buffer indices 0..2 dedicated tx, 3..4 dedicated rx, 5..10 programmable
   localparam int RX_BASE      = 3;
   // Buffer image: 14 bytes per buffer
   localparam int BUF_BYTES    = 14;
   localparam int BUF_W        = 112;
   // Control register bit positions
   localparam int CTL_SEND_REQ = 3;
   localparam int CTL_ABORT    = 6;
   localparam int MOD_ABORT    = 4;
   // Std id low byte extended flag position
   localparam int EXT_BIT_POS  = 3;
   localparam int EXT_BYTE_POS = 1;
   // Receive filter modes
   typedef enum logic [1:0] {
      CMB_RFM_FILTER = 2'h0,
      CMB_RFM_STD    = 2'h1,
      CMB_RFM_EXT    = 2'h2,
      CMB_RFM_ALL    = 2'h3
   } cmb_rfm_t;
   // Functional modes
   typedef enum logic [1:0] {
      CMB_MODE_LEGACY   = 2'h0,
      CMB_MODE_ENHANCED = 2'h1,
      CMB_MODE_FIFO     = 2'h2
   } cmb_fmode_t;
   // Link-side transmit sequencing
   typedef enum logic [1:0] {
      CMB_TX_IDLE = 2'h0,
      CMB_TX_BUSY = 2'h1
   } cmb_txst_t;
   // Reset values
   localparam logic [10:0] DIR_RESET = 11'h007;
endpackage : cmb_pkg

// file: test/cmb_link_model.sv
// Far-side link model: bus idle, frame timing and per-attempt result
`timescale 1ns/1ns
`default_nettype none
module cmb_link_model (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        tx_start,
   input  wire logic [3:0]  tx_buf,
   input  wire logic        idle_en,
   input  wire logic [1:0]  outcome,
   output logic             bus_idle,
   output logic             tx_done,
   output logic             tx_lost,
   output logic             tx_error,
   output logic [7:0]       n_starts,
   output logic [31:0]      start_log
);
   logic [2:0] cnt;
   ////////////////////////////////////////////////////////////
   // Busy from start; the tail of the count keeps starts apart
   assign bus_idle = idle_en && (cnt == 3'h0) && !tx_start;
   // Frame length counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 3'h0;
      end else if (tx_start) begin
         cnt <= 3'h6;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
      end
   end
   // One result pulse per attempt for outcome 0 to 2 (none for 3), kind set by the bench
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {tx_done, tx_lost, tx_error} <= 3'h0;
      end else begin
         tx_done  <= (cnt == 3'h5) && (outcome == 2'h0);
         tx_lost  <= (cnt == 3'h5) && (outcome == 2'h1);
         tx_error <= (cnt == 3'h5) && (outcome == 2'h2);
      end
   end
   // Start log, newest buffer in the low nibble
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         n_starts  <= 8'h00;
         start_log <= 32'h0;
      end else if (tx_start) begin
         n_starts  <= n_starts + 8'h01;
         start_log <= {start_log[27:0], tx_buf};
      end
   end
endmodule : cmb_link_model
`default_nettype wire

// file: test/test_can_message_buffer_handling.sv
// Testbench for the message buffer handling block
`timescale 1ns/1ns
`default_nettype none
module test_can_message_buffer_handling;
   localparam int SET = 0;
   localparam int CLR = 1;
   localparam int CLF = 2;
   localparam int CLD = 3;
   localparam int ABT = 4;
   localparam logic [111:0] IMGA = {14{8'hA5}};
   localparam logic [111:0] IMGB = {14{8'h5A}};
   localparam logic [111:0] XBIT = 112'h800;
   logic         ref_clk, rst_n, abort_all_request, wr_en, wr_auto_reply, idle_en;
   logic         set_send_request, clr_send_request, clr_full, clr_done_irq;
   logic         bus_idle, tx_done, tx_lost, tx_error, rx_valid, rx_error, rx_ext;
   logic         rx_remote, rx_hit, tx_start, bus_error_irq_flag, irq;
   logic [1:0]   func_mode, wr_priority, receive_filter_mode, outcome;
   logic [5:0]   buffer_select_reg;
   logic [3:0]   wr_buf, ctl_buf, rd_buf, rx_target, tx_buf;
   logic [4:0]   rx_filter, filter_hit_code;
   logic [7:0]   n_starts, n_seen;
   logic [31:0]  start_log;
   logic [111:0] wr_image, assembly_buffer, rd_image;
   logic [10:0]  send_done_irq_enable, send_request, abort_done_flag, lost_arbitration_flag;
   logic [10:0]  send_error_flag, send_done_irq_flag, buffer_full_flag, rx_remote_flag;
   int           err_total, n_tests, k;
   // Receive cases: filter mode, error, hit, remote, extended, loaded
   logic [6:0]   tab [8] = '{7'h2A, 7'h29, 7'h48, 7'h4B, 7'h0B, 7'h00, 7'h71, 7'h18};
   logic [3:0]   ord [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
   logic [1:0]   pr  [5] = '{2'h1, 2'h3, 2'h3, 2'h0, 2'h2};

   cmb_msg_buf cmb_msg_buf_i (
      .ref_clk, .rst_n, .func_mode, .abort_all_request, .buffer_select_reg, .wr_en,
      .wr_buf, .wr_image, .wr_priority, .wr_auto_reply, .set_send_request,
      .clr_send_request, .ctl_buf, .clr_full, .clr_done_irq, .clr_bus_err_irq(1'b0),
      .send_done_irq_enable, .receive_filter_mode, .rd_buf, .bus_idle, .tx_done,
      .tx_lost, .tx_error, .rx_valid, .rx_error, .rx_ext, .rx_remote, .rx_hit, .rx_filter,
      .rx_target, .assembly_buffer, .tx_start, .tx_buf, .rd_image, .send_request,
      .abort_done_flag, .lost_arbitration_flag, .send_error_flag, .send_done_irq_flag,
      .bus_error_irq_flag, .buffer_full_flag, .rx_remote_flag, .filter_hit_code, .irq
   );
   cmb_link_model cmb_link_model_i (
      .ref_clk, .rst_n, .tx_start, .tx_buf, .idle_en, .outcome, .bus_idle, .tx_done,
      .tx_lost, .tx_error, .n_starts, .start_log
   );
   ////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Inputs move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic check(input string what, input logic [111:0] seen, input logic [111:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   // One-cycle control pulse on one buffer, or on all buffers for abort-all
   task automatic ctl(input logic [3:0] b, input int op);
      ctl_buf = b;
      case (op)
         SET: set_send_request = 1'b1;
         CLR: clr_send_request = 1'b1;
         CLF: clr_full = 1'b1;
         CLD: clr_done_irq = 1'b1;
         default: abort_all_request = 1'b1;
      endcase
      tick(1);
      {set_send_request, clr_send_request, clr_full, clr_done_irq, abort_all_request} = '0;
   endtask : ctl
   task automatic wr(input logic [3:0] b, input logic [111:0] img, input logic [1:0] p,
                     input logic ar);
      {wr_buf, wr_image, wr_priority, wr_auto_reply} = {b, img, p, ar};
      wr_en = 1'b1;
      tick(1);
      wr_en = 1'b0;
   endtask : wr
   // Frame from the far side; fl is error, hit, remote, extended
   task automatic rx(input logic [3:0] t, input logic [111:0] img, input logic [4:0] f,
                     input logic [3:0] fl);
      {rx_target, assembly_buffer, rx_filter} = {t, img, f};
      {rx_error, rx_hit, rx_remote, rx_ext} = fl;
      rx_valid = !fl[3];
      tick(1);
      {rx_valid, rx_error} = 2'h0;
      tick(1);
   endtask : rx
   // Bounded wait: 0 request clear, 1 lost flag, 2 error flag, 3 new start
   task automatic wait_on(input int op, input int b);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 300 && !hit; i++) begin
         case (op)
            0: hit = (send_request[b] === 1'b0);
            1: hit = (lost_arbitration_flag[b] === 1'b1);
            2: hit = (send_error_flag[b] === 1'b1);
            default: hit = (n_starts !== n_seen);
         endcase
         if (!hit) tick(1);
      end
      if (!hit) begin
         err_total++;
         $display("BAD wait %0d exp 1 seen 0", op);
         complete_run();
      end
   endtask : wait_on
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rst_n, abort_all_request, wr_en, wr_auto_reply, idle_en, rx_valid} = '0;
      {set_send_request, clr_send_request, clr_full, clr_done_irq, rx_error} = '0;
      {rx_ext, rx_remote, rx_hit, rx_filter, rx_target, assembly_buffer} = '0;
      {func_mode, wr_priority, receive_filter_mode, outcome, buffer_select_reg} = '0;
      {wr_buf, ctl_buf, rd_buf, wr_image, n_seen} = '0;
      send_done_irq_enable = 11'h001;
      err_total = 0;
      n_tests = 0;
      repeat (12) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      tick(1);
      check("req rst", send_request, 11'h000);
      check("irq rst", irq, 1'b0);
      ctl(4'h5, SET);
      tick(1);
      check("rx dir", send_request[5], 1'b0);
      $display("test reset finished");
      wr(4'h0, IMGA, 2'h0, 1'b0);
      ctl(4'h0, SET);
      tick(1);
      check("ready", send_request[0], 1'b1);
      tick(5);
      check("no start", n_starts, 8'h00);
      outcome = 2'h1;
      idle_en = 1'b1;
      wait_on(1, 0);
      check("lost req", send_request[0], 1'b1);
      outcome = 2'h0;
      wait_on(0, 0);
      check("done flag", send_done_irq_flag[0], 1'b1);
      check("retry", n_starts, 8'h02);
      tick(1);
      check("irq done", irq, 1'b1);
      ctl(4'h0, CLD);
      tick(1);
      check("irq clr", irq, 1'b0);
      $display("test send finished");
      idle_en = 1'b0;
      outcome = 2'h2;
      ctl(4'h0, SET);
      idle_en = 1'b1;
      wait_on(2, 0);
      idle_en = 1'b0;
      check("err req", send_request[0], 1'b1);
      check("bus err", bus_error_irq_flag, 1'b1);
      tick(1);
      check("irq err", irq, 1'b1);
      ctl(4'h0, CLR);
      tick(1);
      check("abort req", send_request[0], 1'b0);
      check("abort done", abort_done_flag[0], 1'b1);
      ctl(4'h0, SET);
      tick(1);
      check("flags clr", {abort_done_flag[0], lost_arbitration_flag[0], send_error_flag[0]},
            3'h0);
      outcome = 2'h0;
      n_seen = n_starts;
      idle_en = 1'b1;
      wait_on(3, 0);
      ctl(4'h0, ABT);
      wait_on(0, 0);
      check("late abort", abort_done_flag[0], 1'b0);
      idle_en = 1'b0;
      ctl(4'h1, SET);
      tick(1);
      ctl(4'h2, SET);
      tick(1);
      ctl(4'h0, ABT);
      tick(2);
      check("abort all", {send_request[2:1], abort_done_flag[2:1]}, 4'h3);
      wr(4'h1, IMGA, 2'h0, 1'b0);
      ctl(4'h1, SET);
      wr(4'h1, IMGB, 2'h0, 1'b0);
      rd_buf = 4'h1;
      tick(2);
      check("locked", rd_image, IMGA);
      ctl(4'h1, CLR);
      $display("test abort finished");
      func_mode = 2'h1;
      buffer_select_reg = 6'h03;
      for (k = 0; k < 5; k++) begin
         wr(ord[k], IMGA, pr[k], 1'b0);
         ctl(ord[k], SET);
      end
      idle_en = 1'b1;
      for (k = 0; k < 5; k++) wait_on(0, ord[k]);
      check("order", start_log[19:0], 20'h21605);
      idle_en = 1'b0;
      $display("test priority finished");
      func_mode = 2'h0;
      rx(4'h3, IMGA, 5'h05, 4'h7);
      check("full", buffer_full_flag[3], 1'b1);
      rd_buf = 4'h3;
      tick(2);
      check("image ext", rd_image, IMGA | XBIT);
      check("hit 3b", filter_hit_code, 5'h05);
      check("remote", rx_remote_flag[3], 1'b1);
      rx(4'h3, IMGB, 5'h01, 4'h4);
      tick(1);
      check("lockout", rd_image, IMGA | XBIT);
      ctl(4'h3, CLF);
      rx(4'h3, IMGB, 5'h01, 4'h4);
      tick(1);
      check("image std", rd_image, IMGB & ~XBIT);
      check("no remote", rx_remote_flag[3], 1'b0);
      for (k = 0; k < 8; k++) begin
         receive_filter_mode = tab[k][6:5];
         rx(4'h4, IMGA, 5'h02, tab[k][4:1]);
         check("rx mode", buffer_full_flag[4], tab[k][0]);
         ctl(4'h4, CLF);
      end
      receive_filter_mode = 2'h0;
      $display("test receive finished");
      func_mode = 2'h1;
      buffer_select_reg = 6'h01;
      rx(4'h4, IMGA, 5'h13, 4'h4);
      rd_buf = 4'h4;
      tick(2);
      check("hit 5b", filter_hit_code, 5'h13);
      wr(4'h5, IMGB, 2'h0, 1'b1);
      rx(4'h5, IMGA, 5'h07, 4'h6);
      check("auto req", send_request[5], 1'b1);
      check("tx discard", buffer_full_flag[5], 1'b0);
      rd_buf = 4'h5;
      tick(2);
      check("reply img", rd_image, IMGB);
      idle_en = 1'b1;
      wait_on(0, 5);
      check("reply sent", start_log[3:0], 4'h5);
      rx(4'h5, IMGA, 5'h07, 4'h4);
      check("discard", {buffer_full_flag[5], send_request[5]}, 2'h0);
      $display("test auto reply finished");
      complete_run();
   end
endmodule : test_can_message_buffer_handling
`default_nettype wire
